// ==== pwsm_pkg.sv ====
// Constants and types shared by the power-save and clock-fail monitor.
// Assumes a single system clock domain and a 32-bit Avalon-MM slave port.
package pwsm_pkg;

    // Register byte offsets.
    localparam logic [3:0] OFS_OSC_CTL = 4'h0;
    localparam logic [3:0] OFS_CLK_DIV = 4'h4;
    localparam logic [3:0] OFS_STATUS  = 4'h8;

    // Oscillator control field positions.
    localparam int OSC_CUR_LSB   = 12;
    localparam int OSC_NEW_LSB   = 8;
    localparam int OSC_LOCK_BIT  = 7;
    localparam int OSC_FAIL_BIT  = 3;
    localparam int OSC_PLL_BIT   = 1;
    localparam int OSC_GO_BIT    = 0;

    // Clock divisor field positions.
    localparam int DIV_RET_BIT   = 15;
    localparam int DIV_RATIO_LSB = 12;
    localparam int DIV_DOZE_BIT  = 11;

    // Oscillator source codes.
    localparam logic [2:0] OSC_FAST_RC = 3'h0;
    localparam logic [2:0] OSC_PRIMARY = 3'h2;
    localparam logic [2:0] OSC_LP      = 3'h4;
    localparam logic [2:0] OSC_SLOW_RC = 3'h5;

    // Reset values.
    localparam logic [2:0] RST_OSC     = 3'h2;
    localparam logic       RST_PLL     = 1'b0;
    localparam logic [2:0] RST_RATIO   = 3'h0;

    // Low-power RC periods without a monitored edge before failure.
    localparam int FAIL_RC_TICKS = 4;

    // Power-save instruction operand codes.
    localparam logic OP_SLEEP = 1'b0;
    localparam logic OP_IDLE  = 1'b1;

    typedef struct packed {
        logic       ret;
        logic [2:0] ratio;
        logic       doze;
    } pwsm_div_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_SLEEP,
        ST_IDLE
    } pwsm_state_t;

endpackage : pwsm_pkg

// ==== pwsm_top.sv ====
// Power-save sequencer, doze divider and fail-safe clock monitor.
// Assumes all inputs are synchronous to CLK_SYS; the low-power RC and
// monitored oscillator arrive as one-cycle tick pulses.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module pwsm_top #(
    parameter int FAIL_TICKS = pwsm_pkg::FAIL_RC_TICKS
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        CLOCK_SWITCH_CONFIG_BIT,
    input  wire logic        WATCHDOG_ENABLE,
    input  wire logic        WATCHDOG_TIMEOUT,
    input  wire logic        POWER_SAVE_INSTR,
    input  wire logic        POWER_SAVE_OPERAND,
    input  wire logic        IRQ_PENDING,
    input  wire logic        LOW_POWER_RC_TICK,
    input  wire logic        MON_OSC_EDGE,
    output logic             LOW_POWER_RC_RUN,
    output logic             SYS_OSC_RUN,
    output logic [2:0]       ACTIVE_OSC,
    output logic             PLL_ENABLE,
    output logic             CPU_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             WATCHDOG_CLEAR,
    output logic             CLOCK_FAIL_TRAP,
    output logic             WAKE_UP
);

    logic                  fsm_en;
    logic                  sw_en;
    pwsm_pkg::pwsm_state_t state_q;
    logic [2:0]            cur_osc_q;
    logic [2:0]            new_osc_q;
    logic                  pll_q;
    logic                  lock_q;
    logic                  fail_q;
    pwsm_pkg::pwsm_div_t   div_q;
    logic                  ack_q;
    logic                  irq_hold_q;
    logic [7:0]            fail_cnt_q;
    logic [7:0]            fail_cnt_d;
    logic                  fail_det;
    logic [6:0]            doze_cnt_q;
    logic [6:0]            doze_mask;
    logic                  doze_tick;
    logic                  wr_take;
    logic                  rd_take;
    logic                  wake_evt;
    logic [31:0]           rd_mux;
    logic                  dog_clr_q;
    logic                  trap_q;
    logic                  wake_q;

    // Unprogrammed configuration bit turns both features off.
    assign sw_en  = ~CLOCK_SWITCH_CONFIG_BIT;
    assign fsm_en = ~CLOCK_SWITCH_CONFIG_BIT;

    // Every access takes exactly one wait cycle so read data can be
    // registered without a combinational path to the bus.
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign wr_take = AVS_WRITE & ack_q;
    assign rd_take = AVS_READ & ~ack_q;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (AVS_ADDRESS)
            pwsm_pkg::OFS_OSC_CTL: begin
                rd_mux[pwsm_pkg::OSC_CUR_LSB +: 3]  = cur_osc_q;
                rd_mux[pwsm_pkg::OSC_NEW_LSB +: 3]  = new_osc_q;
                rd_mux[pwsm_pkg::OSC_LOCK_BIT]      = lock_q;
                rd_mux[pwsm_pkg::OSC_FAIL_BIT]      = fail_q;
                rd_mux[pwsm_pkg::OSC_PLL_BIT]       = pll_q;
            end
            pwsm_pkg::OFS_CLK_DIV: begin
                rd_mux[pwsm_pkg::DIV_RET_BIT]         = div_q.ret;
                rd_mux[pwsm_pkg::DIV_RATIO_LSB +: 3]  = div_q.ratio;
                rd_mux[pwsm_pkg::DIV_DOZE_BIT]        = div_q.doze;
            end
            pwsm_pkg::OFS_STATUS: begin
                rd_mux[1:0] = state_q;
                rd_mux[2]   = fsm_en;
                rd_mux[3]   = irq_hold_q;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= 32'h0;
        end else if (rd_take) begin
            AVS_READDATA <= rd_mux;
        end
    end

    // Oscillator selection. A failure overrides a software switch in
    // the same cycle; the PLL setting is left untouched so the fast RC
    // fallback runs through the same multiplier.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cur_osc_q <= pwsm_pkg::RST_OSC;
            new_osc_q <= pwsm_pkg::RST_OSC;
            pll_q     <= pwsm_pkg::RST_PLL;
            lock_q    <= 1'b0;
        end else if (fail_det) begin
            cur_osc_q <= pwsm_pkg::OSC_FAST_RC;
            new_osc_q <= pwsm_pkg::OSC_FAST_RC;
        end else if (wr_take && AVS_ADDRESS == pwsm_pkg::OFS_OSC_CTL
                     && sw_en && !lock_q) begin
            if (AVS_BYTEENABLE[1]) begin
                new_osc_q <= AVS_WRITEDATA[pwsm_pkg::OSC_NEW_LSB +: 3];
            end
            if (AVS_BYTEENABLE[0]) begin
                pll_q  <= AVS_WRITEDATA[pwsm_pkg::OSC_PLL_BIT];
                lock_q <= AVS_WRITEDATA[pwsm_pkg::OSC_LOCK_BIT];
                if (AVS_WRITEDATA[pwsm_pkg::OSC_GO_BIT]) begin
                    cur_osc_q <= AVS_BYTEENABLE[1]
                        ? AVS_WRITEDATA[pwsm_pkg::OSC_NEW_LSB +: 3]
                        : new_osc_q;
                end
            end
        end
    end

    // Failure flag: a new failure wins over a software clear.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            fail_q <= 1'b0;
        end else if (fail_det) begin
            fail_q <= 1'b1;
        end else if (wr_take && AVS_ADDRESS == pwsm_pkg::OFS_OSC_CTL
                     && AVS_BYTEENABLE[0]
                     && AVS_WRITEDATA[pwsm_pkg::OSC_FAIL_BIT]) begin
            fail_q <= 1'b0;
        end
    end

    // Missing-edge counter on low-power RC ticks. It is held clear in
    // Sleep, when disabled, and once running on the fast RC fallback.
    always_comb begin
        fail_cnt_d = fail_cnt_q;
        fail_det   = 1'b0;
        if (!fsm_en || state_q == pwsm_pkg::ST_SLEEP || MON_OSC_EDGE
            || cur_osc_q == pwsm_pkg::OSC_FAST_RC) begin
            fail_cnt_d = 8'h0;
        end else if (LOW_POWER_RC_TICK) begin
            if (fail_cnt_q == 8'(FAIL_TICKS - 1)) begin
                fail_det   = 1'b1;
                fail_cnt_d = 8'h0;
            end else begin
                fail_cnt_d = fail_cnt_q + 8'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            fail_cnt_q <= 8'h0;
        end else begin
            fail_cnt_q <= fail_cnt_d;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= fail_det;
        end
    end

    // Doze control. Return-on-interrupt clears the enable bit; a
    // software write in the same cycle takes precedence.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            div_q.ret   <= 1'b0;
            div_q.ratio <= pwsm_pkg::RST_RATIO;
            div_q.doze  <= 1'b0;
        end else if (wr_take && AVS_ADDRESS == pwsm_pkg::OFS_CLK_DIV
                     && AVS_BYTEENABLE[1]) begin
            div_q.ret   <= AVS_WRITEDATA[pwsm_pkg::DIV_RET_BIT];
            div_q.ratio <= AVS_WRITEDATA[pwsm_pkg::DIV_RATIO_LSB +: 3];
            div_q.doze  <= AVS_WRITEDATA[pwsm_pkg::DIV_DOZE_BIT];
        end else if (div_q.ret && IRQ_PENDING) begin
            div_q.doze <= 1'b0;
        end
    end

    // The CPU enable is a one-in-2^n strobe of the system clock, so
    // both domains share edges and stay in lock step.
    assign doze_mask = 7'((8'h1 << div_q.ratio) - 8'h1);
    assign doze_tick = ~div_q.doze
                     | ((doze_cnt_q & doze_mask) == 7'h0);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            doze_cnt_q <= 7'h0;
        end else begin
            doze_cnt_q <= doze_cnt_q + 7'h1;
        end
    end

    // Power-save sequencer. ST_ENTER lasts one cycle; interrupts seen
    // there or in the instruction cycle are held and wake afterwards.
    assign wake_evt = IRQ_PENDING | irq_hold_q | WATCHDOG_TIMEOUT;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q    <= pwsm_pkg::ST_RUN;
            irq_hold_q <= 1'b0;
            dog_clr_q  <= 1'b0;
            wake_q     <= 1'b0;
        end else begin
            dog_clr_q <= 1'b0;
            wake_q    <= 1'b0;
            case (state_q)
                pwsm_pkg::ST_RUN: begin
                    if (POWER_SAVE_INSTR) begin
                        state_q    <= pwsm_pkg::ST_ENTER;
                        irq_hold_q <= IRQ_PENDING;
                        dog_clr_q  <= WATCHDOG_ENABLE;
                    end
                end
                pwsm_pkg::ST_ENTER: begin
                    irq_hold_q <= irq_hold_q | IRQ_PENDING;
                    state_q <= (POWER_SAVE_OPERAND == pwsm_pkg::OP_IDLE)
                             ? pwsm_pkg::ST_IDLE : pwsm_pkg::ST_SLEEP;
                end
                pwsm_pkg::ST_SLEEP, pwsm_pkg::ST_IDLE: begin
                    if (wake_evt) begin
                        state_q    <= pwsm_pkg::ST_RUN;
                        irq_hold_q <= 1'b0;
                        wake_q     <= 1'b1;
                    end
                end
                default: begin
                    state_q <= pwsm_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Clock enables. Sleep stops the source; the current selection is
    // kept so wake-up resumes on the same oscillator.
    assign SYS_OSC_RUN   = state_q != pwsm_pkg::ST_SLEEP;
    assign PERIPH_CLK_EN = state_q != pwsm_pkg::ST_SLEEP;
    assign CPU_CLK_EN    = (state_q == pwsm_pkg::ST_RUN)
                         & doze_tick;

    always_comb begin
        if (state_q == pwsm_pkg::ST_SLEEP) begin
            LOW_POWER_RC_RUN = WATCHDOG_ENABLE;
        end else begin
            LOW_POWER_RC_RUN = fsm_en | WATCHDOG_ENABLE
                | (cur_osc_q == pwsm_pkg::OSC_SLOW_RC);
        end
    end

    assign ACTIVE_OSC      = cur_osc_q;
    assign PLL_ENABLE      = pll_q;
    assign WATCHDOG_CLEAR  = dog_clr_q;
    assign CLOCK_FAIL_TRAP = trap_q;
    assign WAKE_UP         = wake_q;

endmodule : pwsm_top

// ==== pwsm_asserts.sv ====
// Concurrent checks on the ports of the power-save and clock-fail monitor.
// Assumes one clock domain; bound to every pwsm_top instance.
`timescale 1ns/1ps
module pwsm_asserts (
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       CLOCK_SWITCH_CONFIG_BIT,
    input wire logic       WATCHDOG_ENABLE,
    input wire logic       WATCHDOG_TIMEOUT,
    input wire logic       POWER_SAVE_INSTR,
    input wire logic       IRQ_PENDING,
    input wire logic       LOW_POWER_RC_RUN,
    input wire logic       SYS_OSC_RUN,
    input wire logic [2:0] ACTIVE_OSC,
    input wire logic       PLL_ENABLE,
    input wire logic       CPU_CLK_EN,
    input wire logic       PERIPH_CLK_EN,
    input wire logic       WATCHDOG_CLEAR,
    input wire logic       CLOCK_FAIL_TRAP,
    input wire logic       WAKE_UP
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    a_sleep_gates:
    assert property (!SYS_OSC_RUN |-> !PERIPH_CLK_EN && !CPU_CLK_EN)
        else $error("clocks live while oscillator is off");
    a_watchdog_clear:
    assert property (WATCHDOG_CLEAR |-> $past(POWER_SAVE_INSTR)
                     && WATCHDOG_ENABLE)
        else $error("watchdog clear without power-save entry");
    a_watchdog_keeps_rc:
    assert property (WATCHDOG_ENABLE && !CPU_CLK_EN |-> LOW_POWER_RC_RUN)
        else $error("rc clock stopped with watchdog on");
    a_monitor_keeps_rc:
    assert property (!CLOCK_SWITCH_CONFIG_BIT && SYS_OSC_RUN
                     |-> LOW_POWER_RC_RUN)
        else $error("rc clock stopped with monitor on");
    a_trap_fast_rc:
    assert property (CLOCK_FAIL_TRAP |-> ACTIVE_OSC == pwsm_pkg::OSC_FAST_RC
                     && $past(ACTIVE_OSC) != pwsm_pkg::OSC_FAST_RC)
        else $error("trap without switch to fast rc");
    a_trap_pll:
    assert property (CLOCK_FAIL_TRAP |-> $stable(PLL_ENABLE))
        else $error("pll setting changed on failure");
    a_trap_gated:
    assert property (CLOCK_FAIL_TRAP |-> $past(SYS_OSC_RUN)
                     && !$past(CLOCK_SWITCH_CONFIG_BIT))
        else $error("trap while monitor should be off");
    a_wake_cause:
    assert property (WAKE_UP |-> $past(IRQ_PENDING || WATCHDOG_TIMEOUT)
                     || $past(IRQ_PENDING, 2) || $past(IRQ_PENDING, 3))
        else $error("wake without a wake event");
    a_sleep_osc:
    assert property (!SYS_OSC_RUN |=> $stable(ACTIVE_OSC))
        else $error("clock source changed in sleep");
endmodule : pwsm_asserts

bind pwsm_top pwsm_asserts u_chk (.*);

// ==== pwsm_top_bench.sv ====
// Self-checking bench for pwsm_top: bus, monitor, switch, sleep, idle, doze.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module pwsm_top_bench;
    localparam int FT = 2;
    logic        CLK_SYS, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
    logic        CLOCK_SWITCH_CONFIG_BIT, WATCHDOG_ENABLE, WATCHDOG_TIMEOUT;
    logic        POWER_SAVE_INSTR, POWER_SAVE_OPERAND, IRQ_PENDING;
    logic        LOW_POWER_RC_TICK, MON_OSC_EDGE, LOW_POWER_RC_RUN;
    logic [2:0]  ACTIVE_OSC;
    logic        SYS_OSC_RUN, PLL_ENABLE, CPU_CLK_EN, PERIPH_CLK_EN;
    logic        WATCHDOG_CLEAR, CLOCK_FAIL_TRAP, WAKE_UP;
    int          errors, tests_run;

    pwsm_top #(.FAIL_TICKS(FT)) u_dut (.*);

    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end

    task automatic final_report;
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic hang;
        errors++;
        $display("wrong value wait expected done seen timeout");
        final_report();
    endtask : hang

    // Request is held until waitrequest is seen low, then dropped for a
    // cycle so no signal is driven twice in one time step.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
        if (n >= 20) hang();
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : bus

    task automatic do_reset;
        RST <= 1'b1;
        repeat (8) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
    endtask : do_reset

    task automatic t_reset_vals;
        chk("reset osc", pwsm_pkg::RST_OSC, ACTIVE_OSC);
        bus(0, pwsm_pkg::OFS_CLK_DIV, 0);
        chk("reset div", 0, rd);
        bus(0, 4'hc, 0);
        chk("unmapped", 0, rd);
    endtask : t_reset_vals

    task automatic t_monitor;
        int nt;
        int at;
        nt = 0;
        at = -1;
        bus(1, pwsm_pkg::OFS_OSC_CTL, 32'h0203);
        chk("pll on", 1, PLL_ENABLE);
        // Edges are given for the first nine cycles so the count must
        // restart; a count that ignores edges traps too early.
        for (int i = 0; i < 24; i++) begin
            if (CLOCK_FAIL_TRAP === 1'b1 && at < 0) at = nt;
            LOW_POWER_RC_TICK <= (i % 3 == 0);
            MON_OSC_EDGE <= (i % 3 == 1) && (i < 9);
            if (i >= 9 && i % 3 == 0) nt++;
            @(posedge CLK_SYS);
        end
        chk("ticks to trap", FT, at);
        chk("fallback", pwsm_pkg::OSC_FAST_RC, ACTIVE_OSC);
        chk("pll kept", 1, PLL_ENABLE);
    endtask : t_monitor

    task automatic t_switch;
        int tr;
        tr = 0;
        bus(1, pwsm_pkg::OFS_OSC_CTL, {21'h0, pwsm_pkg::OSC_SLOW_RC, 8'h01});
        chk("switch", pwsm_pkg::OSC_SLOW_RC, ACTIVE_OSC);
        bus(0, pwsm_pkg::OFS_OSC_CTL, 0);
        chk("current", pwsm_pkg::OSC_SLOW_RC, rd[14:12]);
        bus(1, pwsm_pkg::OFS_OSC_CTL, 32'h0080);
        bus(1, pwsm_pkg::OFS_OSC_CTL, {21'h0, pwsm_pkg::OSC_PRIMARY, 8'h01});
        chk("locked", pwsm_pkg::OSC_SLOW_RC, ACTIVE_OSC);
        CLOCK_SWITCH_CONFIG_BIT <= 1'b1;
        do_reset();
        bus(1, pwsm_pkg::OFS_OSC_CTL, {21'h0, pwsm_pkg::OSC_SLOW_RC, 8'h01});
        chk("switch off", pwsm_pkg::RST_OSC, ACTIVE_OSC);
        // Ticks with no monitored edge would trap within a few cycles
        // if the monitor ignored the configuration bit.
        LOW_POWER_RC_TICK <= 1'b1;
        repeat (2 * FT + 2) begin
            @(posedge CLK_SYS);
            tr += (CLOCK_FAIL_TRAP !== 1'b0);
        end
        LOW_POWER_RC_TICK <= 1'b0;
        chk("monitor off", 0, tr);
        chk("no fallback", pwsm_pkg::RST_OSC, ACTIVE_OSC);
        CLOCK_SWITCH_CONFIG_BIT <= 1'b0;
    endtask : t_switch

    task automatic t_psave(input logic op, input int src);
        logic [2:0] osc;
        int         n;
        logic       rc_ex;
        osc = ACTIVE_OSC;
        n = 0;
        POWER_SAVE_INSTR <= 1'b1;
        POWER_SAVE_OPERAND <= op;
        IRQ_PENDING <= (src == 2);
        @(posedge CLK_SYS);
        POWER_SAVE_INSTR <= 1'b0;
        IRQ_PENDING <= 1'b0;
        @(posedge CLK_SYS);
        chk("watchdog clear", WATCHDOG_ENABLE, WATCHDOG_CLEAR);
        chk("cpu halt", 0, CPU_CLK_EN);
        if (src != 2) begin
            @(posedge CLK_SYS);
            chk("sys osc", op, SYS_OSC_RUN);
            chk("periph", op, PERIPH_CLK_EN);
            rc_ex = op ? (!CLOCK_SWITCH_CONFIG_BIT | WATCHDOG_ENABLE)
                       : WATCHDOG_ENABLE;
            chk("rc run", rc_ex, LOW_POWER_RC_RUN);
            IRQ_PENDING <= (src == 0);
            WATCHDOG_TIMEOUT <= (src == 1);
        end
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WAKE_UP !== 1'b1 && n < 6);
        if (n >= 6) hang();
        chk("cpu back", 1, CPU_CLK_EN);
        chk("same osc", osc, ACTIVE_OSC);
        IRQ_PENDING <= 1'b0;
        WATCHDOG_TIMEOUT <= 1'b0;
        @(posedge CLK_SYS);
    endtask : t_psave

    task automatic t_doze;
        int cnt;
        int pk;
        pk = 0;
        for (int r = 0; r < 8; r++) begin
            bus(1, pwsm_pkg::OFS_CLK_DIV, 32'h0800 | (r << 12));
            cnt = 0;
            repeat (256) begin
                @(posedge CLK_SYS);
                cnt += (CPU_CLK_EN === 1'b1);
                pk += (PERIPH_CLK_EN !== 1'b1);
            end
            chk("doze rate", 256 >> r, cnt);
        end
        chk("periph full", 0, pk);
        bus(1, pwsm_pkg::OFS_CLK_DIV, 32'h3800);
        IRQ_PENDING <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        bus(0, pwsm_pkg::OFS_CLK_DIV, 0);
        chk("no return", 32'h3800, rd);
        bus(1, pwsm_pkg::OFS_CLK_DIV, 32'hb800);
        repeat (3) @(posedge CLK_SYS);
        bus(0, pwsm_pkg::OFS_CLK_DIV, 0);
        chk("return", 32'hb000, rd);
        IRQ_PENDING <= 1'b0;
    endtask : t_doze

    initial begin
        errors = 0;
        tests_run = 0;
        RST = 1'b1;
        AVS_ADDRESS = 4'h0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 32'h0;
        AVS_BYTEENABLE = 4'hf;
        CLOCK_SWITCH_CONFIG_BIT = 1'b0;
        WATCHDOG_ENABLE = 1'b1;
        WATCHDOG_TIMEOUT = 1'b0;
        POWER_SAVE_INSTR = 1'b0;
        POWER_SAVE_OPERAND = 1'b0;
        IRQ_PENDING = 1'b0;
        LOW_POWER_RC_TICK = 1'b0;
        MON_OSC_EDGE = 1'b0;
        do_reset();
        t_reset_vals();
        t_monitor();
        t_switch();
        t_psave(pwsm_pkg::OP_SLEEP, 0);
        t_psave(pwsm_pkg::OP_IDLE, 1);
        t_psave(pwsm_pkg::OP_SLEEP, 2);
        t_psave(pwsm_pkg::OP_IDLE, 2);
        WATCHDOG_ENABLE <= 1'b0;
        t_psave(pwsm_pkg::OP_SLEEP, 0);
        CLOCK_SWITCH_CONFIG_BIT <= 1'b1;
        t_psave(pwsm_pkg::OP_IDLE, 0);
        CLOCK_SWITCH_CONFIG_BIT <= 1'b0;
        WATCHDOG_ENABLE <= 1'b1;
        t_doze();
        final_report();
    end
endmodule : pwsm_top_bench
